// [rtl/drwd_pkg.sv]
/*
  Constants for the data-space decoder and read-only program-memory window.
  Assumes an 8-bit data space and a 12-bit program-memory address.
*/
package drwd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PADDR_W    = 12;
  localparam int unsigned OFFSET_W   = 6;
  localparam int unsigned BLOCK_W    = 6;

  // ----------------------------------------------------------------
  // Window range
  // ----------------------------------------------------------------
  localparam logic [7:0] WIN_LO      = 8'h40;
  localparam logic [7:0] WIN_HI      = 8'h7f;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INDEX_X      = 8'h80;
  localparam logic [7:0] ADDR_SHORT_W      = 8'h83;
  localparam logic [7:0] ADDR_PA_LATCH     = 8'hc0;
  localparam logic [7:0] ADDR_PB_LATCH     = 8'hc1;
  localparam logic [7:0] ADDR_PA_DIR       = 8'hc4;
  localparam logic [7:0] ADDR_PB_DIR       = 8'hc5;
  localparam logic [7:0] ADDR_INT_CFG      = 8'hc8;
  localparam logic [7:0] ADDR_BLOCK_SEL    = 8'hc9;
  localparam logic [7:0] ADDR_PA_CFG       = 8'hcc;
  localparam logic [7:0] ADDR_PB_CFG       = 8'hcd;
  localparam logic [7:0] ADDR_CONV_RESULT  = 8'hd0;
  localparam logic [7:0] ADDR_CONV_CTRL    = 8'hd1;
  localparam logic [7:0] ADDR_TMR_PRESCALE = 8'hd2;
  localparam logic [7:0] ADDR_TMR_COUNT    = 8'hd3;
  localparam logic [7:0] ADDR_TMR_STATUS   = 8'hd4;
  localparam logic [7:0] ADDR_WDG_COUNT    = 8'hd8;
  localparam logic [7:0] ADDR_ACCUM        = 8'hff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT          = 8'h00;
  localparam logic [7:0] RST_CONV_CTRL     = 8'h40;
  localparam logic [7:0] RST_TMR_PRESCALE  = 8'h7f;
  localparam logic [7:0] RST_TMR_COUNT     = 8'hff;
  localparam logic [7:0] RST_TMR_STATUS    = 8'h00;
  localparam logic [7:0] RST_WDG_COUNT     = 8'hfe;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // ----------------------------------------------------------------
  // Program-memory vectors
  // ----------------------------------------------------------------
  localparam logic [11:0] VEC_INT_LO       = 12'hff0;
  localparam logic [11:0] VEC_INT_HI       = 12'hff7;
  localparam logic [11:0] VEC_NMI_LO       = 12'hffc;
  localparam logic [11:0] VEC_RESET_LO     = 12'hffe;

endpackage

// [rtl/drwd_decode.sv]
/*
  Data-space decoder with the read-only program-memory window and the core,
  port, converter, timer and watchdog registers at their fixed addresses.
  Assumes a CPU core issuing single-cycle reads and writes on clk_sys_i, and a
  program memory answering combinationally on its address.
*/
`timescale 1ns/10ps

module drwd_decode #(
  parameter logic [7:0] CONV_CTRL_WMASK = 8'hbf
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // CPU data-space access
  input  wire logic [7:0]  cpu_addr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic        cpu_wr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic      [7:0]  cpu_rdata_o,
  output logic             win_sel_o,
  // Program memory
  output logic      [11:0] pmem_addr_o,
  input  wire logic [7:0]  pmem_rdata_i,
  output logic             pmem_vec_o,
  // Ports and peripherals
  input  wire logic [7:0]  port_a_pins_i,
  input  wire logic [7:0]  port_b_pins_i,
  output logic      [7:0]  port_a_output_latch_o,
  output logic      [7:0]  port_b_output_latch_o,
  output logic      [7:0]  port_a_direction_o,
  output logic      [7:0]  port_b_direction_o,
  output logic      [7:0]  port_a_pin_config_o,
  output logic      [7:0]  port_b_pin_config_o,
  output logic      [7:0]  interrupt_config_o,
  input  wire logic [7:0]  converter_result_i,
  input  wire logic [7:0]  conv_status_i,
  output logic      [7:0]  converter_control_o,
  output logic      [7:0]  timer_prescaler_o,
  output logic      [7:0]  timer_downcounter_o,
  output logic      [7:0]  timer_status_control_o,
  output logic      [7:0]  watchdog_counter_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The window address must be exactly the block bits over the offset bits.
  if (drwd_pkg::BLOCK_W + drwd_pkg::OFFSET_W != drwd_pkg::PADDR_W) begin : g_bad_split
    $error("Window address fields do not fill the program address.");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] core_reg [0:3];
  logic [7:0] accum_reg;
  logic [7:0] block_sel_reg;
  logic [7:0] int_cfg_reg;
  logic [7:0] pa_latch_reg, pb_latch_reg, pa_dir_reg, pb_dir_reg, pa_cfg_reg, pb_cfg_reg;
  logic [7:0] conv_ctrl_reg, tmr_pre_reg, tmr_cnt_reg, tmr_stat_reg, wdg_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic in_window = (cpu_addr_i >= drwd_pkg::WIN_LO) && (cpu_addr_i <= drwd_pkg::WIN_HI);
  wire logic in_core   = (cpu_addr_i >= drwd_pkg::ADDR_INDEX_X) && (cpu_addr_i <= drwd_pkg::ADDR_SHORT_W);
  wire logic [1:0] core_idx = cpu_addr_i[1:0];
  wire logic wr_core   = cpu_wr_i && in_core;
  wire logic wr_accum  = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_ACCUM);
  wire logic wr_blk    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_BLOCK_SEL);
  wire logic wr_icfg   = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_INT_CFG);
  wire logic wr_pal    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_PA_LATCH);
  wire logic wr_pbl    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_PB_LATCH);
  wire logic wr_pad    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_PA_DIR);
  wire logic wr_pbd    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_PB_DIR);
  wire logic wr_pac    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_PA_CFG);
  wire logic wr_pbc    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_PB_CFG);
  wire logic wr_cctl   = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_CONV_CTRL);
  wire logic wr_tpre   = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_TMR_PRESCALE);
  wire logic wr_tcnt   = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_TMR_COUNT);
  wire logic wr_tst    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_TMR_STATUS);
  wire logic wr_wdg    = cpu_wr_i && (cpu_addr_i == drwd_pkg::ADDR_WDG_COUNT);

  // Block bits on top, data-address offset below: block n starts at n*64.
  wire logic [11:0] win_addr = {block_sel_reg[drwd_pkg::BLOCK_W-1:0],
                                cpu_addr_i[drwd_pkg::OFFSET_W-1:0]};

  // Output-pin bits show the latch, input-pin bits the live pin.
  wire logic [7:0] pa_view = (pa_latch_reg & pa_dir_reg) | (port_a_pins_i & ~pa_dir_reg);
  wire logic [7:0] pb_view = (pb_latch_reg & pb_dir_reg) | (port_b_pins_i & ~pb_dir_reg);
  // Read-only status bits come from the converter; the rest echo control.
  wire logic [7:0] cctl_view = (conv_ctrl_reg & CONV_CTRL_WMASK) | (conv_status_i & ~CONV_CTRL_WMASK);

  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = drwd_pkg::READ_UNMAPPED;
    if (in_window) begin
      rdata_next = pmem_rdata_i;
    end else if (in_core) begin
      rdata_next = core_reg[core_idx];
    end else begin
      case (cpu_addr_i)
        drwd_pkg::ADDR_ACCUM:        rdata_next = accum_reg;
        drwd_pkg::ADDR_PA_LATCH:     rdata_next = pa_view;
        drwd_pkg::ADDR_PB_LATCH:     rdata_next = pb_view;
        drwd_pkg::ADDR_PA_DIR:       rdata_next = pa_dir_reg;
        drwd_pkg::ADDR_PB_DIR:       rdata_next = pb_dir_reg;
        drwd_pkg::ADDR_PA_CFG:       rdata_next = pa_cfg_reg;
        drwd_pkg::ADDR_PB_CFG:       rdata_next = pb_cfg_reg;
        drwd_pkg::ADDR_CONV_RESULT:  rdata_next = converter_result_i;
        drwd_pkg::ADDR_CONV_CTRL:    rdata_next = cctl_view;
        drwd_pkg::ADDR_TMR_PRESCALE: rdata_next = tmr_pre_reg;
        drwd_pkg::ADDR_TMR_COUNT:    rdata_next = tmr_cnt_reg;
        drwd_pkg::ADDR_TMR_STATUS:   rdata_next = tmr_stat_reg;
        drwd_pkg::ADDR_WDG_COUNT:    rdata_next = wdg_reg;
        default:                     rdata_next = drwd_pkg::READ_UNMAPPED;
      endcase
    end
  end

  assign cpu_rdata_o = rdata_next;
  assign win_sel_o   = in_window;
  assign pmem_addr_o = win_addr;
  assign pmem_vec_o  = ((win_addr >= drwd_pkg::VEC_INT_LO) && (win_addr <= drwd_pkg::VEC_INT_HI)) ||
                       (win_addr >= drwd_pkg::VEC_NMI_LO);

  assign port_a_output_latch_o  = pa_latch_reg;
  assign port_b_output_latch_o  = pb_latch_reg;
  assign port_a_direction_o     = pa_dir_reg;
  assign port_b_direction_o     = pb_dir_reg;
  assign port_a_pin_config_o    = pa_cfg_reg;
  assign port_b_pin_config_o    = pb_cfg_reg;
  assign interrupt_config_o     = int_cfg_reg;
  assign converter_control_o    = conv_ctrl_reg;
  assign timer_prescaler_o      = tmr_pre_reg;
  assign timer_downcounter_o    = tmr_cnt_reg;
  assign timer_status_control_o = tmr_stat_reg;
  assign watchdog_counter_o     = wdg_reg;

  // ----------------------------------------------------------------
  // Registers without reset
  // ----------------------------------------------------------------
  // These hold whatever power-up left in them until software writes them.
  always_ff @(posedge clk_sys_i) begin
    if (wr_blk) begin
      block_sel_reg <= cpu_wdata_i;
    end
    if (wr_icfg) begin
      int_cfg_reg <= cpu_wdata_i;
    end
    if (wr_accum) begin
      accum_reg <= cpu_wdata_i;
    end
    if (wr_core) begin
      core_reg[core_idx] <= cpu_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Registers with reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_latch_reg <= drwd_pkg::RST_PORT;
      pb_latch_reg <= drwd_pkg::RST_PORT;
      pa_dir_reg   <= drwd_pkg::RST_PORT;
      pb_dir_reg   <= drwd_pkg::RST_PORT;
      pa_cfg_reg   <= drwd_pkg::RST_PORT;
      pb_cfg_reg   <= drwd_pkg::RST_PORT;
    end else begin
      if (wr_pal) pa_latch_reg <= cpu_wdata_i;
      if (wr_pbl) pb_latch_reg <= cpu_wdata_i;
      if (wr_pad) pa_dir_reg   <= cpu_wdata_i;
      if (wr_pbd) pb_dir_reg   <= cpu_wdata_i;
      if (wr_pac) pa_cfg_reg   <= cpu_wdata_i;
      if (wr_pbc) pb_cfg_reg   <= cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_ctrl_reg <= drwd_pkg::RST_CONV_CTRL;
      tmr_pre_reg   <= drwd_pkg::RST_TMR_PRESCALE;
      tmr_cnt_reg   <= drwd_pkg::RST_TMR_COUNT;
      tmr_stat_reg  <= drwd_pkg::RST_TMR_STATUS;
      wdg_reg       <= drwd_pkg::RST_WDG_COUNT;
    end else begin
      if (wr_cctl) conv_ctrl_reg <= cpu_wdata_i;
      if (wr_tpre) tmr_pre_reg   <= cpu_wdata_i;
      if (wr_tcnt) tmr_cnt_reg   <= cpu_wdata_i;
      if (wr_tst)  tmr_stat_reg  <= cpu_wdata_i;
      if (wr_wdg)  wdg_reg       <= cpu_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Marks that block select holds a written value, so its hold can be checked.
  logic blk_known_reg;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blk_known_reg <= 1'b0;
    end else if (wr_blk) begin
      blk_known_reg <= 1'b1;
    end
  end

  a_window_decode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_addr_i[7:6] == 2'b01) |-> (win_sel_o && cpu_rdata_o == pmem_rdata_i))
    else $error("Window address not decoded as window.");
  a_window_addr: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (wr_blk ##1 (cpu_rd_i && win_sel_o)) |->
    (pmem_addr_o == {$past(cpu_wdata_i[5:0]), cpu_addr_i[5:0]}))
    else $error("Window address not formed from block and offset.");
  a_block_base: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (win_sel_o && cpu_addr_i == drwd_pkg::WIN_LO) |-> (pmem_addr_o[5:0] == 6'h00))
    else $error("Window base does not start a block.");
  a_block_sel_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!wr_blk && blk_known_reg) |=> $stable(block_sel_reg))
    else $error("Block select changed without a write.");
  a_block_sel_rd: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_addr_i == drwd_pkg::ADDR_BLOCK_SEL) |-> (cpu_rdata_o == drwd_pkg::READ_UNMAPPED))
    else $error("Block select readback exposed.");
  a_port_view: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_addr_i == drwd_pkg::ADDR_PA_LATCH) |->
    (cpu_rdata_o == ((pa_latch_reg & pa_dir_reg) | (port_a_pins_i & ~pa_dir_reg))))
    else $error("Port A read mixes latch and pins wrongly.");
  a_latch_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_pbl |=> (port_b_output_latch_o == $past(cpu_wdata_i)))
    else $error("Port B latch did not take the write.");
  a_reserved_noeff: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_wr_i && cpu_addr_i == 8'hc2) |=> $stable(port_a_direction_o) && $stable(timer_prescaler_o))
    else $error("Reserved write changed a register.");
  a_dir_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_pad |=> (port_a_direction_o == $past(cpu_wdata_i)))
    else $error("Port A direction did not take the write.");
  a_window_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    win_sel_o == (cpu_addr_i[7:6] == 2'b01))
    else $error("Window select does not match the window range.");
  a_reset_values: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> (port_a_output_latch_o == drwd_pkg::RST_PORT &&
                         port_b_direction_o == drwd_pkg::RST_PORT &&
                         port_a_pin_config_o == drwd_pkg::RST_PORT &&
                         timer_prescaler_o == drwd_pkg::RST_TMR_PRESCALE))
    else $error("Register missed its reset value after reset.");
  a_accum_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_accum |=> (accum_reg == $past(cpu_wdata_i)))
    else $error("Accumulator did not take the write.");
  a_core_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_core |=> (core_reg[$past(core_idx)] == $past(cpu_wdata_i)))
    else $error("Index or short-direct register did not take the write.");
  a_icfg_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_icfg |=> (interrupt_config_o == $past(cpu_wdata_i)))
    else $error("Interrupt configuration did not take the write.");
  a_icfg_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_addr_i == drwd_pkg::ADDR_INT_CFG) |-> (cpu_rdata_o == drwd_pkg::READ_UNMAPPED))
    else $error("Interrupt configuration readback exposed.");
  a_conv_result: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_addr_i == drwd_pkg::ADDR_CONV_RESULT) |-> (cpu_rdata_o == converter_result_i))
    else $error("Converter result read does not show the converter.");
  a_conv_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_cctl |=> (converter_control_o == $past(cpu_wdata_i)))
    else $error("Converter control did not take the write.");
  a_timer_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_tcnt |=> (timer_downcounter_o == $past(cpu_wdata_i)))
    else $error("Timer down-counter did not take the write.");
  a_vec_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    pmem_vec_o == ((pmem_addr_o[11:3] == drwd_pkg::VEC_INT_LO[11:3]) ||
                   (pmem_addr_o[11:2] == drwd_pkg::VEC_NMI_LO[11:2])))
    else $error("Vector flag disagrees with the vector areas.");

  c_window_read: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) wr_blk ##1 (cpu_rd_i && win_sel_o));
  c_port_mixed:  cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cpu_rd_i && cpu_addr_i == drwd_pkg::ADDR_PA_LATCH && pa_dir_reg != 8'h00 && pa_dir_reg != 8'hff));
  c_accum_write: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) wr_accum);
  c_vector_read: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) cpu_rd_i && pmem_vec_o && win_sel_o);
  c_reserved_wr: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) cpu_wr_i && cpu_addr_i == 8'hc2);

endmodule

// [dv/drwd_pmem_model.sv]
/*
  Program-memory model for the data-space decoder bench.
  Assumes the decoder presents a 12-bit address and expects the byte back
  combinationally in the same cycle.
*/
`timescale 1ns/10ps
module drwd_pmem_model (
  // Program memory port
  input  wire logic [11:0] pmem_addr_i,
  output logic      [7:0]  pmem_rdata_o
);
  // -----------------------------------------------------------------
  // Contents
  // -----------------------------------------------------------------
  // Each byte mixes block and offset bits, so within a block a wrong offset reads a different byte; some wrong blocks read the same byte.
  // The vector area at the top of the 4K range is filled the same way.
  assign pmem_rdata_o = pmem_addr_i[7:0] ^ {pmem_addr_i[11:8], 4'h5};
endmodule

// [dv/data_rom_window_decode_bench.sv]
/*
  Self-checking bench for the data-space decoder and program-memory window.
  Assumes combinational read data and writes taken at the rising clock edge.
*/
`timescale 1ns/10ps
module data_rom_window_decode_bench;
  logic        clk_sys_i, resetn_i, cpu_rd, cpu_wr, win_sel, pvec;
  logic [7:0]  cpu_addr, cpu_wdata, rdata, prdata, pa_pins, pb_pins, conv_res, conv_stat;
  logic [7:0]  pa_lat, pb_lat, pa_dir, pb_dir, pa_cfg, pb_cfg, int_cfg, conv_ctl, tpre, tcnt, tsta, wdg;
  logic [11:0] paddr;
  logic [7:0]  exp_q[$];
  logic [7:0]  wv[13];
  logic [7:0]  rw_addr[13] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'hc4, 8'hc5, 8'hcc, 8'hcd,
                               8'hd2, 8'hd3, 8'hd4, 8'hd8};
  logic [7:0]  rsv_addr[11] = '{8'hc2, 8'hc3, 8'hc6, 8'hc7, 8'hca, 8'hcb, 8'hce, 8'hcf, 8'hd5, 8'hd9, 8'hfe};
  logic [7:0]  la, lb, v;
  logic [5:0]  blk, off, blk_shadow;
  int          err_count, n_checks;
  integer      seed;

  drwd_decode i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cpu_addr_i(cpu_addr), .cpu_rd_i(cpu_rd),
    .cpu_wr_i(cpu_wr), .cpu_wdata_i(cpu_wdata), .cpu_rdata_o(rdata), .win_sel_o(win_sel),
    .pmem_addr_o(paddr), .pmem_rdata_i(prdata), .pmem_vec_o(pvec), .port_a_pins_i(pa_pins),
    .port_b_pins_i(pb_pins), .port_a_output_latch_o(pa_lat), .port_b_output_latch_o(pb_lat),
    .port_a_direction_o(pa_dir), .port_b_direction_o(pb_dir), .port_a_pin_config_o(pa_cfg),
    .port_b_pin_config_o(pb_cfg), .interrupt_config_o(int_cfg), .converter_result_i(conv_res),
    .conv_status_i(conv_stat), .converter_control_o(conv_ctl), .timer_prescaler_o(tpre),
    .timer_downcounter_o(tcnt), .timer_status_control_o(tsta), .watchdog_counter_o(wdg));

  drwd_pmem_model i_pmem (.pmem_addr_i(paddr), .pmem_rdata_o(prdata));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    cpu_rd = 1'b0;
  endtask

  // Presents a read and notes the byte the monitor must see at the next rising edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    cpu_addr = a;
    cpu_wr = 1'b0;
    cpu_rd = 1'b1;
    exp_q.push_back(e);
    #1;
  endtask

  task automatic look(input logic [7:0] a);
    @(negedge clk_sys_i);
    cpu_addr = a;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    #1;
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Clock, monitor and timeout
  // -----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (cpu_rd === 1'b1 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
  end

  initial begin
    #(20000 * 50);
    err_count++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    seed = 32'hf4f1adfc;
    resetn_i = 1'b0;
    {cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = '0;
    pa_pins = $random(seed);
    pb_pins = $random(seed);
    conv_res = $random(seed);
    conv_stat = $random(seed);
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    chk({pa_lat, pb_lat, pa_dir, pb_dir}, 32'h0);
    chk({pa_cfg, pb_cfg, tsta, conv_ctl}, 32'h40);
    chk({tpre, tcnt, wdg, 8'h00}, 32'h7ffffe00);
    rd(8'hc0, pa_pins);
    rd(8'hd3, 8'hff);
    $display("test reset values done");
    for (int i = 0; i < 13; i++) begin
      wv[i] = 8'($random(seed)) & ((rw_addr[i] == 8'hc4 || rw_addr[i] == 8'hcc) ? 8'h0f : 8'hff);
      wr(rw_addr[i], wv[i]);
    end
    for (int i = 0; i < 13; i++) rd(rw_addr[i], wv[i]);
    $display("test read write registers done");
    la = 8'($random(seed)) & 8'h0f;
    lb = $random(seed);
    wr(8'hc0, la);
    wr(8'hc1, lb);
    pa_pins = $random(seed);
    pb_pins = $random(seed);
    rd(8'hc0, (la & wv[5]) | (pa_pins & ~wv[5]));
    rd(8'hc1, (lb & wv[6]) | (pb_pins & ~wv[6]));
    chk({pa_lat, pb_lat}, {la, lb});
    $display("test port latches done");
    v = $random(seed);
    wr(8'hc8, v);
    rd(8'hc8, 8'h00);
    chk(int_cfg, v);
    wr(8'hd0, ~conv_res);
    rd(8'hd0, conv_res);
    v = $random(seed);
    wr(8'hd1, v);
    rd(8'hd1, (v & 8'hbf) | (conv_stat & 8'h40));
    chk(conv_ctl, v);
    for (int i = 0; i < 11; i++) begin
      wr(rsv_addr[i], 8'hff);
      rd(rsv_addr[i], 8'h00);
    end
    rd(8'hc4, wv[5]);
    $display("test write-only and reserved done");
    for (int i = 0; i < 4; i++) begin
      blk = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : (i == 2) ? 6'h3f : 6'($random(seed));
      blk_shadow = blk;
      wr(8'hc9, {2'b00, blk_shadow});
      #1;
      chk(rdata, 8'h00);
      for (int j = 0; j < 3; j++) begin
        off = (j == 0) ? 6'h00 : (j == 1) ? 6'h3f : 6'($random(seed));
        rd({2'b01, off}, rom({blk, off}));
        chk({win_sel, paddr}, {1'b1, blk, off});
      end
    end
    blk_shadow = 6'h3f;
    wr(8'hc9, {2'b00, blk_shadow});
    for (int j = 48; j < 64; j++) begin
      rd({2'b01, 6'(j)}, rom({6'h3f, 6'(j)}));
      chk(pvec, (j < 56) || (j > 59));
    end
    look(8'h3f);
    chk(win_sel, 1'b0);
    look(8'h80);
    chk(win_sel, 1'b0);
    $display("test window done");
    blk_shadow = 6'h05;
    wr(8'hc9, {2'b00, blk_shadow});
    @(negedge clk_sys_i);
    cpu_wr = 1'b0;
    resetn_i = 1'b0;
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    chk(pa_lat, 8'h00);
    look(8'h4a);
    chk(rdata, rom(12'h14a));
    chk(paddr, 12'h14a);
    look(8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk(exp_q.size(), 0);
    $display("test reset retention done");
    end_sim();
  end
endmodule
